// ---- osc_gclk_regs.v ----
`timescale 1ns/1ps
`include "osc_gclk_defines.vh"

module osc_gclk_regs #(
  parameter NUM_GCLK = 9,
  parameter STARTUP_SHIFT = 0,
  parameter [11:0] PLL_VERSION = 12'h101,
  parameter [3:0] PLL_VARIANT = 4'h0,
  parameter [11:0] OSC0_VERSION = 12'h102,
  parameter [3:0] OSC0_VARIANT = 4'h0
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_por,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_system_rc_clock,
  input wire [9:0] i_gclk_sources,
  output wire o_osc32k_enable,
  output wire [1:0] o_osc32k_mode,
  output wire o_slow_xtal_out_is_io,
  output wire o_osc32k_crystal,
  output wire o_osc32k_current_mode,
  output wire o_osc32k_ready,
  output wire o_rc120m_enable,
  output wire [NUM_GCLK-1:0] o_gclk
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function is_gcc;
    input [9:0] a;
    begin
      is_gcc = (a >= `GCC_BASE_OFS) && (a <= `GCC_LAST_OFS) && (a[1:0] == 2'h0);
    end
  endfunction

  function [7:0] gcc_index;
    input [9:0] a;
    reg [9:0] d;
    begin
      d = a - `GCC_BASE_OFS;
      gcc_index = d[9:2];
    end
  endfunction

  function [19:0] startup_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: startup_cycles = `STARTUP_C0;
        3'h1: startup_cycles = `STARTUP_C1;
        3'h2: startup_cycles = `STARTUP_C2;
        3'h3: startup_cycles = `STARTUP_C3;
        3'h4: startup_cycles = `STARTUP_C4;
        3'h5: startup_cycles = `STARTUP_C5;
        3'h6: startup_cycles = `STARTUP_C6;
        default: startup_cycles = `STARTUP_C7;
      endcase
    end
  endfunction

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  wire rst_any;
  wire [9:0] addr;
  wire setup_ph;
  wire wr_en;
  assign rst_any = i_rst | i_por;
  assign addr = i_paddr[9:0];
  assign setup_ph = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & i_pwrite;

  wire hi_zero;
  wire mapped;
  assign hi_zero = (i_paddr[31:10] == 22'h000000) && (i_paddr[1:0] == 2'h0);
  assign mapped = hi_zero && ((addr == `OSC32K_CTRL_OFS) || (addr == `RC120M_CFG_OFS) ||
                  (addr == `SCRATCH0_OFS) || (addr == `SCRATCH1_OFS) || is_gcc(addr) ||
                  (addr == `PLL_VER_OFS) || (addr == `OSC0_VER_OFS) ||
                  (addr == `UNLOCK_OFS) || (addr == `STATUS_OFS));

  // zero-wait slave: every access phase completes at once
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  wire wr_ok;
  assign wr_ok = wr_en & mapped;

  // ----------------------------------------
  // unlock for scratch registers
  // ----------------------------------------
  reg armed_r;
  reg [9:0] armed_addr_r;
  wire unlock_hit;
  assign unlock_hit = wr_ok && (addr == `UNLOCK_OFS) &&
                      (i_pwdata[31:24] == `UNLOCK_KEY);

  // one write after unlock, then relock
  always @(posedge i_clk_sys or posedge rst_any)
  begin
    if (rst_any)
    begin
      armed_r <= 1'b0;
      armed_addr_r <= 10'h000;
    end
    else if (unlock_hit)
    begin
      armed_r <= 1'b1;
      armed_addr_r <= i_pwdata[9:0];
    end
    else if (wr_en)
    begin
      armed_r <= 1'b0;
    end
  end

  wire scr0_wr;
  wire scr1_wr;
  assign scr0_wr = wr_ok && (addr == `SCRATCH0_OFS) && armed_r && (armed_addr_r == addr);
  assign scr1_wr = wr_ok && (addr == `SCRATCH1_OFS) && armed_r && (armed_addr_r == addr);

  // ----------------------------------------
  // power-on-only registers
  // ----------------------------------------
  reg [31:0] osc32k_control_r;
  reg [31:0] scratch0_r;
  reg [31:0] scratch1_r;

  always @(posedge i_clk_sys or posedge i_por)
  begin
    if (i_por)
    begin
      osc32k_control_r <= `REG_RESET;
      scratch0_r <= `REG_RESET;
      scratch1_r <= `REG_RESET;
    end
    else
    begin
      if (wr_ok && (addr == `OSC32K_CTRL_OFS))
        osc32k_control_r <= i_pwdata & `OSC32K_WMASK;
      if (scr0_wr)
        scratch0_r <= i_pwdata;
      if (scr1_wr)
        scratch1_r <= i_pwdata;
    end
  end

  // ----------------------------------------
  // fast rc configuration
  // ----------------------------------------
  reg [31:0] rc120m_config_r;
  always @(posedge i_clk_sys or posedge rst_any)
  begin
    if (rst_any)
      rc120m_config_r <= `REG_RESET;
    else if (wr_ok && (addr == `RC120M_CFG_OFS))
      rc120m_config_r <= i_pwdata & `RC120M_WMASK;
  end
  assign o_rc120m_enable = rc120m_config_r[`RC120M_EN_BIT];

  // ----------------------------------------
  // slow oscillator controls
  // ----------------------------------------
  wire [1:0] mode_w;
  wire [2:0] startup_w;
  assign mode_w = osc32k_control_r[`OSC32K_MODE_LSB+1:`OSC32K_MODE_LSB];
  assign startup_w = osc32k_control_r[`OSC32K_STARTUP_LSB+2:`OSC32K_STARTUP_LSB];
  assign o_osc32k_enable = osc32k_control_r[`OSC32K_EN_BIT];
  assign o_osc32k_mode = mode_w;
  assign o_slow_xtal_out_is_io = (mode_w == `MODE_EXT_CLOCK);
  assign o_osc32k_crystal = (mode_w == `MODE_XTAL) || (mode_w == `MODE_XTAL_CURRENT);
  assign o_osc32k_current_mode = (mode_w == `MODE_XTAL_CURRENT);

  // ----------------------------------------
  // startup wait on system rc edges
  // ----------------------------------------
  reg rc_s1_r;
  reg rc_s2_r;
  reg rc_s3_r;
  always @(posedge i_clk_sys or posedge rst_any)
  begin
    if (rst_any)
    begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end
    else
    begin
      rc_s1_r <= i_system_rc_clock;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end
  wire rc_edge;
  assign rc_edge = rc_s2_r & ~rc_s3_r;

  wire [19:0] startup_target;
  assign startup_target = startup_cycles(startup_w) >> STARTUP_SHIFT;

  reg [19:0] su_cnt_r;
  reg [19:0] su_cnt_nxt;
  reg ready_r;
  // count while enabled, restart when off
  always @*
  begin
    su_cnt_nxt = su_cnt_r;
    if (!o_osc32k_enable)
      su_cnt_nxt = 20'h00000;
    else if (rc_edge && (su_cnt_r != `STARTUP_SAT))
      su_cnt_nxt = su_cnt_r + 20'h00001;
  end

  always @(posedge i_clk_sys or posedge rst_any)
  begin
    if (rst_any)
    begin
      su_cnt_r <= 20'h00000;
      ready_r <= 1'b0;
    end
    else
    begin
      su_cnt_r <= su_cnt_nxt;
      ready_r <= o_osc32k_enable && (su_cnt_nxt >= startup_target);
    end
  end
  assign o_osc32k_ready = ready_r;

  // ----------------------------------------
  // generic clock channels
  // ----------------------------------------
  wire [32*NUM_GCLK-1:0] gcc_flat;
  genvar g;
  generate
    for (g = 0; g < NUM_GCLK; g = g + 1)
    begin : gch
      reg [31:0] gcc_r;
      always @(posedge i_clk_sys or posedge rst_any)
      begin
        if (rst_any)
          gcc_r <= `REG_RESET;
        else if (wr_ok && is_gcc(addr) && (gcc_index(addr) == g))
          gcc_r <= i_pwdata & `GCC_WMASK;
      end
      assign gcc_flat[32*g+31:32*g] = gcc_r;

      gen_clock_channel #(
        .DIV_W(8)
      ) u_chan (
        .i_rst(rst_any),
        .i_src_clks(i_gclk_sources),
        .i_source_select(gcc_r[`GCC_SRC_LSB+3:`GCC_SRC_LSB]),
        .i_divide_enable(gcc_r[`GCC_DIVIDE_ENABLE_BIT]),
        .i_div(gcc_r[`GCC_DIV_LSB+7:`GCC_DIV_LSB]),
        .i_gate(gcc_r[`GCC_GATE_BIT]),
        .o_gclk(o_gclk[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [31:0] rd_mux;
  integer k;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (hi_zero)
    begin
      case (addr)
        `OSC32K_CTRL_OFS: rd_mux = osc32k_control_r;
        `RC120M_CFG_OFS: rd_mux = rc120m_config_r;
        `SCRATCH0_OFS: rd_mux = scratch0_r;
        `SCRATCH1_OFS: rd_mux = scratch1_r;
        `STATUS_OFS: rd_mux = {31'h0000_0000, ready_r};
        `PLL_VER_OFS: rd_mux = {12'h000, PLL_VARIANT, 4'h0, PLL_VERSION};
        `OSC0_VER_OFS: rd_mux = {12'h000, OSC0_VARIANT, 4'h0, OSC0_VERSION};
        default: rd_mux = 32'h0000_0000;
      endcase
      for (k = 0; k < NUM_GCLK; k = k + 1)
      begin
        if (is_gcc(addr) && (gcc_index(addr) == k))
          rd_mux = gcc_flat[32*k +: 32];
      end
    end
  end

  // captured in setup so data is stable through the access phase
  reg [31:0] prdata_r;
  always @(posedge i_clk_sys or posedge rst_any)
  begin
    if (rst_any)
      prdata_r <= 32'h0000_0000;
    else if (setup_ph && !i_pwrite)
      prdata_r <= rd_mux;
  end
  assign o_prdata = prdata_r;

endmodule // osc_gclk_regs

// ---- osc_gclk_defines.vh ----
`ifndef OSC_GCLK_DEFINES_VH
`define OSC_GCLK_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OSC32K_CTRL_OFS 10'h03C
`define RC120M_CFG_OFS 10'h044
`define SCRATCH0_OFS 10'h048
`define SCRATCH1_OFS 10'h04C
`define GCC_BASE_OFS 10'h060
`define GCC_LAST_OFS 10'h080
`define PLL_VER_OFS 10'h3D4
`define OSC0_VER_OFS 10'h3D8
`define UNLOCK_OFS 10'h018
`define STATUS_OFS 10'h050

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define OSC32K_EN_BIT 0
`define OSC32K_MODE_LSB 8
`define OSC32K_STARTUP_LSB 16
`define RC120M_EN_BIT 0
`define GCC_GATE_BIT 0
`define GCC_DIVIDE_ENABLE_BIT 1
`define GCC_SRC_LSB 8
`define GCC_DIV_LSB 16
`define VER_VARIANT_LSB 16
`define UNLOCK_KEY_LSB 24
`define OSC32K_WMASK 32'h0007_0301
`define RC120M_WMASK 32'h0000_0001
`define GCC_WMASK 32'h00FF_0F03

// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define REG_RESET 32'h0000_0000
`define UNLOCK_KEY 8'hAA

// ----------------------------------------
// oscillator modes
// ----------------------------------------
`define MODE_EXT_CLOCK 2'h0
`define MODE_XTAL 2'h1
`define MODE_XTAL_CURRENT 2'h2

// ----------------------------------------
// startup counts in system rc cycles
// ----------------------------------------
`define STARTUP_C0 20'h00000
`define STARTUP_C1 20'h00080
`define STARTUP_C2 20'h02000
`define STARTUP_C3 20'h04000
`define STARTUP_C4 20'h10000
`define STARTUP_C5 20'h20000
`define STARTUP_C6 20'h40000
`define STARTUP_C7 20'h80000
`define STARTUP_SAT 20'hFFFFF
`define GCLK_SRC_LAST 4'h9

`endif

// ---- gen_clock_channel.v ----
`timescale 1ns/1ps
`include "osc_gclk_defines.vh"

module gen_clock_channel #(
  parameter DIV_W = 8
) (
  input wire i_rst,
  input wire [9:0] i_src_clks,
  input wire [3:0] i_source_select,
  input wire i_divide_enable,
  input wire [DIV_W-1:0] i_div,
  input wire i_gate,
  output wire o_gclk
);

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  // reserved codes give a quiet low clock
  wire src_clk;
  assign src_clk = (i_source_select <= `GCLK_SRC_LAST) ? i_src_clks[i_source_select] : 1'b0;

  // ----------------------------------------
  // control crossing into source domain
  // ----------------------------------------
  reg divide_enable_s1_r;
  reg divide_enable_s2_r;
  reg gate_s1_r;
  reg gate_s2_r;
  always @(posedge src_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      divide_enable_s1_r <= 1'b0;
      divide_enable_s2_r <= 1'b0;
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
    end
    else
    begin
      divide_enable_s1_r <= i_divide_enable;
      divide_enable_s2_r <= divide_enable_s1_r;
      gate_s1_r <= i_gate;
      gate_s2_r <= gate_s1_r;
    end
  end

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // division value is quasi-static: change it with the gate closed
  reg [DIV_W-1:0] cnt_r;
  reg div_clk_r;
  always @(posedge src_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= {DIV_W{1'b0}};
      div_clk_r <= 1'b0;
    end
    // >= so a smaller new division value cannot strand the count
    else if (cnt_r >= i_div)
    begin
      cnt_r <= {DIV_W{1'b0}};
      div_clk_r <= ~div_clk_r;
    end
    else
    begin
      cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  wire pre_clk;
  assign pre_clk = divide_enable_s2_r ? div_clk_r : src_clk;

  // ----------------------------------------
  // glitch-free gate
  // ----------------------------------------
  reg gate_n_r;
  always @(negedge pre_clk or posedge i_rst)
  begin
    if (i_rst)
      gate_n_r <= 1'b0;
    else
      gate_n_r <= gate_s2_r;
  end
  assign o_gclk = pre_clk & gate_n_r;

endmodule // gen_clock_channel

// ---- osc_gclk_regs_monitor.sv ----
`timescale 1ns/1ps
`include "osc_gclk_defines.vh"
module osc_gclk_regs_monitor #(
  parameter [11:0] PLL_VERSION = 12'h101,
  parameter [3:0] PLL_VARIANT = 4'h0
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_por,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_osc32k_enable,
  input wire [1:0] o_osc32k_mode,
  input wire o_slow_xtal_out_is_io,
  input wire o_osc32k_crystal,
  input wire o_osc32k_current_mode,
  input wire o_osc32k_ready,
  input wire o_rc120m_enable
);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst || i_por);
  sequence wr_acc(logic [31:0] a);
    i_psel && i_penable && i_pwrite && i_paddr == a;
  endsequence
  sequence rd_setup(logic [31:0] a);
    i_psel && !i_penable && !i_pwrite && i_paddr == a;
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ctrl_write_lands:
    assert property (wr_acc(32'h3C) |=> {o_osc32k_mode, o_osc32k_enable} ==
      {$past(i_pwdata[9:8]), $past(i_pwdata[0])}) else $error("control write lost");
  a_mode_ext_io:
    assert property (o_slow_xtal_out_is_io == (o_osc32k_mode == `MODE_EXT_CLOCK))
      else $error("io decode wrong");
  a_mode_crystal:
    assert property (o_osc32k_crystal == (o_osc32k_mode == `MODE_XTAL ||
      o_osc32k_mode == `MODE_XTAL_CURRENT)) else $error("crystal decode wrong");
  a_mode_current:
    assert property (o_osc32k_current_mode == (o_osc32k_mode == `MODE_XTAL_CURRENT))
      else $error("current decode wrong");
  a_rc_write_lands:
    assert property (wr_acc(32'h44) |=> o_rc120m_enable == $past(i_pwdata[0]))
      else $error("fast rc enable lost");
  a_ready_needs_en:
    assert property (!o_osc32k_enable |=> !o_osc32k_ready) else $error("ready while off");
  a_version_read:
    assert property (rd_setup(32'h3D4) |=> o_prdata ==
      {12'h000, PLL_VARIANT, 4'h0, PLL_VERSION}) else $error("version read wrong");
  // plain reset keeps the slow oscillator setup
  a_rst_keeps_ctrl:
    assert property (@(posedge i_clk_sys) disable iff (i_por) i_rst |=>
      {o_osc32k_mode, o_osc32k_enable} == $past({o_osc32k_mode, o_osc32k_enable}))
      else $error("control lost on reset");
endmodule // osc_gclk_regs_monitor

bind osc_gclk_regs osc_gclk_regs_monitor #(.PLL_VERSION(PLL_VERSION),
  .PLL_VARIANT(PLL_VARIANT)) u_monitor (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_por(i_por), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_osc32k_enable(o_osc32k_enable), .o_osc32k_mode(o_osc32k_mode),
  .o_slow_xtal_out_is_io(o_slow_xtal_out_is_io), .o_osc32k_crystal(o_osc32k_crystal),
  .o_osc32k_current_mode(o_osc32k_current_mode), .o_osc32k_ready(o_osc32k_ready),
  .o_rc120m_enable(o_rc120m_enable));

// ---- osc_gclk_regs_test.sv ----
`timescale 1ns/1ps
`include "osc_gclk_defines.vh"
module osc_gclk_regs_test;
  // ----------------------------------------
  // bench state
  // ----------------------------------------
  localparam [11:0] PV = 12'h2A5; // arbitrary version value
  logic clk, rst, por, psel, pen, pwr, rc, src;
  logic [31:0] paddr, pwdata, seed, d;
  wire [31:0] prdata;
  wire pready, pslverr, ready, rcen;
  wire [8:0] gclk;
  logic [32:0] exp_q[$];
  int num_errors, total_checks, cyc, rises, i;
  int st[3] = '{0, 128 >> 6, 8192 >> 6};
  logic [31:0] ra[6] = '{32'h3C, 32'h44, 32'h48, 32'h4C, 32'h60, 32'h80};
  logic [31:0] gc[4] = '{32'h0001_0103, 32'h0000_0001, 32'h0000_0100, 32'h0000_0A01};
  int lo[4] = '{19, 39, 0, 0};
  int hi[4] = '{21, 41, 0, 0};

  // startup counts shortened by 64 to keep the run short
  osc_gclk_regs #(.STARTUP_SHIFT(6), .PLL_VERSION(PV)) dut (.i_clk_sys(clk), .i_rst(rst),
    .i_por(por), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_system_rc_clock(rc), .i_gclk_sources({{9{src}}, rc}), .o_osc32k_enable(),
    .o_osc32k_mode(), .o_slow_xtal_out_is_io(), .o_osc32k_crystal(),
    .o_osc32k_current_mode(), .o_osc32k_ready(ready), .o_rc120m_enable(rcen),
    .o_gclk(gclk));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish();
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // leading edge wait keeps back-to-back calls from reassigning psel
  task apb(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [32:0] e);
    @(posedge clk);
    if (!w)
      exp_q.push_back(e);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h0);
  endtask
  task rd(input logic [31:0] a, input logic [32:0] e);
    apb(1'b0, a, rnd(), e);
  endtask

  // ----------------------------------------
  // clocks, watchers, timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always #20 rc = ~rc;
  always #10 src = ~src;
  always @(posedge gclk[8]) rises++;
  always @(posedge clk)
  begin
    if (psel && pen && pready === 1'b1 && !pwr)
      cmp({pslverr, prdata}, exp_q.pop_front());
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {rc, src, rst, por, psel, pen, pwr, paddr, pwdata} = {4'h3, 3'h0, 64'h0};
    seed = 32'd15647;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    foreach (ra[i]) rd(ra[i], 33'h0);
    wr(32'h3D4, rnd());
    rd(32'h3D4, {21'h0, PV});
    rd(32'h3DC, {1'b1, 32'h0});
    for (i = 0; i < 4; i++)
    begin
      d = rnd();
      d[9:8] = i[1:0];
      wr(32'h3C, d);
      rd(32'h3C, {1'b0, d & `OSC32K_WMASK});
    end
    d = rnd();
    wr(32'h44, d);
    rd(32'h44, {1'b0, d & `RC120M_WMASK});
    cmp(rcen, d[0]);
    for (i = 0; i < 9; i++)
    begin
      d = rnd();
      wr(32'h60 + 4 * i, d);
      rd(32'h60 + 4 * i, {1'b0, d & `GCC_WMASK});
    end
    // locked writes, wrong target, then proper unlock
    wr(32'h48, d);
    wr(32'h18, {`UNLOCK_KEY, 14'h0, 10'h04C});
    wr(32'h48, d);
    rd(32'h48, 33'h0);
    wr(32'h18, {`UNLOCK_KEY, 14'h0, 10'h048});
    wr(32'h48, d);
    rd(32'h48, {1'b0, d});
    wr(32'h18, {`UNLOCK_KEY, 14'h0, 10'h04C});
    wr(32'h4C, ~d);
    rd(32'h4C, {1'b0, ~d});
    for (i = 0; i < 3; i++)
    begin
      wr(32'h3C, 32'h0);
      wr(32'h3C, {13'h0, i[2:0], 16'h0001});
      if (st[i] > 0)
      begin
        repeat (st[i] * 4 - 6) @(posedge clk);
        #1 cmp(ready, 33'h0);
      end
      repeat (st[i] > 0 ? 20 : 2) @(posedge clk);
      #1 cmp(ready, 33'h1);
    end
    for (i = 0; i < 4; i++)
    begin
      wr(32'h80, gc[i]);
      repeat (20) @(posedge clk);
      rises = 0;
      repeat (160) @(posedge clk);
      cmp(rises >= lo[i] && rises <= hi[i], 33'h1);
    end
    wr(32'h3C, 32'h0000_0101);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(32'h48, {1'b0, d});
    rd(32'h3C, 33'h101);
    rd(32'h80, 33'h0);
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    rd(32'h48, 33'h0);
    rd(32'h3C, 33'h0);
    tally_and_finish;
  end
endmodule // osc_gclk_regs_test
